// ---- hgc_pkg.sv ----
// Shared constants, state types and check-bit helpers for the gateway channels
package hgc_pkg;

  // Control channel parcel layout
  localparam int         CTL_W        = 16;
  localparam int         CTL_PAR_W    = 4;
  localparam int         NIBBLE_W     = 4;
  localparam int         ROUTE_BIT    = 15;
  localparam logic       ROUTE_OUTPUT = 1'b0;
  localparam logic       ROUTE_INPUT  = 1'b1;
  localparam int         NODE_OUT     = 0;
  localparam int         NODE_IN      = 1;
  localparam int         NODES        = 2;

  // Data channel word layout
  localparam int         WORD_W       = 64;
  localparam int         CHK_W        = 8;
  localparam int         SYN_W        = 7;
  localparam int         CODE_POS_MAX = 71;
  localparam int         ADDR_W       = 24;
  localparam int         LEN_W        = 16;

  // Word pacing from clock rate and channel rate
  localparam int         CLK_MHZ        = 40;
  localparam int         RATE_FULL_MBPS = 200;
  localparam int         RATE_HALF_MBPS = 100;
  localparam int         BYTES_PER_WORD = 8;
  localparam int         PACE_W         = 4;
  localparam logic [3:0] PACE_STEP_FULL =
    4'(RATE_FULL_MBPS * (2 ** PACE_W) / (CLK_MHZ * BYTES_PER_WORD));
  localparam logic [3:0] PACE_STEP_HALF =
    4'(RATE_HALF_MBPS * (2 ** PACE_W) / (CLK_MHZ * BYTES_PER_WORD));

  // Inbound control receiver states
  typedef enum logic [1:0] {
    RX_WAIT_FIRST = 2'b01,
    RX_ROUTED     = 2'b10
  } hgc_rx_t;

  // Outbound control sender states
  typedef enum logic [3:0] {
    TX_IDLE    = 4'b0001,
    TX_SEND    = 4'b0010,
    TX_RELEASE = 4'b0100,
    TX_DONE    = 4'b1000
  } hgc_tx_t;

  // Data channel slave states
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_DATA = 3'b010,
    HS_END  = 3'b100
  } hgc_hs_t;

  // Code position of data bit i in the Hamming layout
  function automatic logic [SYN_W-1:0] hgc_dpos(input int i);
    logic [SYN_W-1:0] p;
    int               cnt;
    p   = '0;
    cnt = -1;
    for (int q = 1; q <= CODE_POS_MAX; q++)
    begin
      if ((q & (q - 1)) != 0)
      begin
        cnt++;
        if (cnt == i)
          p = SYN_W'(q);
      end
    end
    return p;
  endfunction : hgc_dpos

  // Data bits covered by check bit k
  function automatic logic [WORD_W-1:0] hgc_synmask(input int k);
    logic [WORD_W-1:0] m;
    logic [SYN_W-1:0]  p;
    m = '0;
    for (int i = 0; i < WORD_W; i++)
    begin
      p    = hgc_dpos(i);
      m[i] = p[k];
    end
    return m;
  endfunction : hgc_synmask

endpackage : hgc_pkg

// ---- hgc_ecc_if.sv ----
// Bundle between the data channel logic and its check-bit decoder
`timescale 1ns/100ps
interface hgc_ecc_if;
  import hgc_pkg::*;
  logic [WORD_W-1:0] data;
  logic [CHK_W-1:0]  check;
  logic [WORD_W-1:0] fixed;
  logic              single;
  logic              double;

  modport dec (input data, check, output fixed, single, double);
  modport user (output data, check, input fixed, single, double);
endinterface : hgc_ecc_if

// ---- hgc_par4.sv ----
// Per-nibble even parity over one control parcel
`timescale 1ns/100ps
module hgc_par4
  import hgc_pkg::*;
(
  // Parcel in, parity out
  input  wire logic [CTL_W-1:0]     data,
  output logic      [CTL_PAR_W-1:0] parity
);

  // One parity bit per nibble
  genvar n;
  generate
    for (n = 0; n < CTL_PAR_W; n++)
    begin : g_nib
      assign parity[n] = ^data[n*NIBBLE_W +: NIBBLE_W];
    end
  endgenerate

endmodule : hgc_par4

// ---- hgc_ecc.sv ----
// Single-error-correcting, double-error-detecting decoder for 64-bit words
`timescale 1ns/100ps
module hgc_ecc
  import hgc_pkg::*;
(
  // Word, check bits and decode result
  hgc_ecc_if.dec e
);

  logic [SYN_W-1:0] syn;
  logic             oddAll;
  logic             synZero;

  // Syndrome bit per Hamming check bit
  genvar k;
  generate
    for (k = 0; k < SYN_W; k++)
    begin : g_syn
      assign syn[k] = e.check[k] ^ (^(e.data & hgc_synmask(k)));
    end
  endgenerate

  // Overall parity separates single from double faults
  assign oddAll   = ^{e.data, e.check};
  assign synZero  = (syn == '0);
  assign e.single = oddAll;
  assign e.double = ~oddAll & ~synZero;

  // Flip the data bit that the syndrome points at
  genvar i;
  generate
    for (i = 0; i < WORD_W; i++)
    begin : g_fix
      assign e.fixed[i] = e.data[i] ^ (oddAll & (syn == hgc_dpos(i)));
    end
  endgenerate

endmodule : hgc_ecc

// ---- hgc_top.sv ----
// Gateway channel logic: control links in and out, data channel slave
//
// What this block does
// - Control traffic moves as 16-bit parcels, one per transfer unit, each way.
// - Each parcel carries 4 parity bits made by the sender and checked by the receiver.
// - The control channel is two separate one-way links, inbound and outbound.
// - Either end may start a control transfer on its own outgoing link at any time.
// - Sender marks a parcel present, receiver marks it taken, sender marks the transfer done.
// - The top bit of the first inbound parcel routes the transfer: 0 to output node, 1 to input node.
// - A node asking while the outbound link is free owns it until it disconnects, the output node first if both ask; the other waits.
// - On the data channel the master supplies the addressing and this slave follows it.
// - Before data the master gives a memory address and a block length in words.
// - Data words are 64 bits with 8 check bits; single-bit errors are corrected.
// - Word rate is 200 Mbytes/s by default and 100 Mbytes/s when the rate select is set.
// - Clear, start and last-word signals steer the data channel.
// - At block end an error indication tells the master whether the block went bad.
`timescale 1ns/100ps
module hgc_top
  import hgc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Inbound control link
  input  wire logic [CTL_W-1:0]     ciData,
  input  wire logic [CTL_PAR_W-1:0] ciParity,
  input  wire logic                 ciPresent,
  input  wire logic                 ciDone,
  output logic                      ciTaken,
  // Delivery to the two nodes
  output logic      [CTL_W-1:0]     rxParcel,
  output logic      [NODES-1:0]     rxValid,
  output logic      [NODES-1:0]     rxEnd,
  // Outbound requests from the two nodes
  input  wire logic [NODES-1:0]     nodeReq,
  input  wire logic [CTL_W-1:0]     nodeParcel [NODES],
  input  wire logic [NODES-1:0]     nodeValid,
  input  wire logic [NODES-1:0]     nodeDisc,
  output logic      [NODES-1:0]     nodeGrant,
  output logic      [NODES-1:0]     nodeReady,
  // Outbound control link
  output logic      [CTL_W-1:0]     coData,
  output logic      [CTL_PAR_W-1:0] coParity,
  output logic                      coPresent,
  output logic                      coDone,
  input  wire logic                 coTaken,
  // Data channel from the master
  input  wire logic                 hsClear,
  input  wire logic                 hsStart,
  input  wire logic [ADDR_W-1:0]    hsAddr,
  input  wire logic [LEN_W-1:0]     hsLen,
  input  wire logic                 hsWordValid,
  input  wire logic [WORD_W-1:0]    hsData,
  input  wire logic [CHK_W-1:0]     hsCheck,
  input  wire logic                 hsLast,
  output logic                      hsReady,
  output logic                      hsStatusValid,
  output logic                      hsStatusErr,
  // Slave memory write port
  output logic                      memWe,
  output logic      [ADDR_W-1:0]    memAddr,
  output logic      [WORD_W-1:0]    memData,
  // Configuration and error flags
  input  wire logic                 rateHalf,
  input  wire logic                 errClear,
  output logic                      ctlParityErr,
  output logic                      dataUncorrErr,
  output logic                      dataCorrected
);

  // ---------------- Inbound control link ----------------
  hgc_rx_t              rxState;
  logic                 route;
  logic [CTL_PAR_W-1:0] rxParCalc;
  wire                  ciAccept = ciPresent & ~ciTaken;
  wire                  ciEnd    = ciDone & ~ciPresent;
  wire                  parBad   = ciAccept & (rxParCalc != ciParity);
  wire                  rxFirst  = (rxState == RX_WAIT_FIRST);
  wire                  dest     = rxFirst ? ciData[ROUTE_BIT] : route;
  wire  [NODES-1:0]     destSel  = (dest == ROUTE_INPUT) ? 2'h2 : 2'h1;

  // Receiver parity check
  hgc_par4 u_rxpar
  (
    .data   (ciData),
    .parity (rxParCalc)
  );

  // Taken follows present, one acceptance per present phase
  always_ff @(posedge clk)
  begin
    if (rst)
      ciTaken <= 1'b0;
    else
      ciTaken <= ciPresent;
  end

  // Route latch and transfer framing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxState <= RX_WAIT_FIRST;
      route   <= ROUTE_OUTPUT;
    end
    else
    begin
      case (rxState)
        RX_WAIT_FIRST:
        begin
          if (ciAccept)
          begin
            route   <= ciData[ROUTE_BIT];
            rxState <= RX_ROUTED;
          end
        end
        RX_ROUTED:
        begin
          if (ciEnd)
            rxState <= RX_WAIT_FIRST;
        end
        default:
          rxState <= RX_WAIT_FIRST;
      endcase
    end
  end

  // Parcel delivery to the selected node
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxParcel <= '0;
      rxValid  <= '0;
      rxEnd    <= '0;
    end
    else
    begin
      if (ciAccept)
        rxParcel <= ciData;
      rxValid <= ciAccept ? destSel : 2'h0;
      rxEnd   <= (ciEnd & ~rxFirst) ? destSel : 2'h0;
    end
  end

  // ---------------- Outbound control link ----------------
  hgc_tx_t              txState;
  hgc_tx_t              next_txState;
  logic                 ownValid;
  logic                 owner;
  logic                 next_ownValid;
  logic                 next_owner;
  logic [CTL_PAR_W-1:0] txParCalc;
  wire  [CTL_W-1:0]     selParcel = nodeParcel[owner];
  wire                  selValid  = nodeValid[owner] & nodeReady[owner];
  wire                  selDisc   = nodeDisc[owner] & nodeReady[owner] & ~nodeValid[owner];
  wire                  txIdle    = (txState == TX_IDLE);
  wire                  grab      = ~ownValid & txIdle & (|nodeReq);
  wire                  grabNode  = nodeReq[NODE_OUT] ? 1'b0 : 1'b1;

  // Sender parity generation
  hgc_par4 u_txpar
  (
    .data   (selParcel),
    .parity (txParCalc)
  );

  // Ownership: a requester takes the free link, output node first if both ask, and holds it until disconnect
  always_comb
  begin
    next_ownValid = ownValid;
    next_owner    = owner;
    if (grab)
    begin
      next_ownValid = 1'b1;
      next_owner    = grabNode;
    end
    else if (txState == TX_DONE)
      next_ownValid = 1'b0;
  end

  // Sender sequence for one parcel or a disconnect
  always_comb
  begin
    next_txState = txState;
    case (txState)
      TX_IDLE:
      begin
        if (ownValid & selValid)
          next_txState = TX_SEND;
        else if (ownValid & selDisc)
          next_txState = TX_DONE;
      end
      TX_SEND:
      begin
        if (coTaken)
          next_txState = TX_RELEASE;
      end
      TX_RELEASE:
      begin
        if (~coTaken)
          next_txState = TX_IDLE;
      end
      TX_DONE:
        next_txState = TX_IDLE;
      default:
        next_txState = TX_IDLE;
    endcase
  end

  // Ownership and handshake registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txState   <= TX_IDLE;
      ownValid  <= 1'b0;
      owner     <= 1'b0;
      nodeGrant <= '0;
      nodeReady <= '0;
    end
    else
    begin
      txState   <= next_txState;
      ownValid  <= next_ownValid;
      owner     <= next_owner;
      nodeGrant <= next_ownValid ? (next_owner ? 2'h2 : 2'h1) : 2'h0;
      nodeReady <= (next_ownValid & (next_txState == TX_IDLE) & (txState != TX_SEND))
                   ? (next_owner ? 2'h2 : 2'h1) : 2'h0;
    end
  end

  // Outbound link pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      coData    <= '0;
      coParity  <= '0;
      coPresent <= 1'b0;
      coDone    <= 1'b0;
    end
    else
    begin
      if (txIdle & ownValid & selValid)
      begin
        coData   <= selParcel;
        coParity <= txParCalc;
      end
      coPresent <= (next_txState == TX_SEND);
      coDone    <= (next_txState == TX_DONE);
    end
  end

  // ---------------- Data channel slave ----------------
  hgc_hs_t          hsState;
  hgc_hs_t          next_hsState;
  logic [ADDR_W-1:0] addr;
  logic [LEN_W-1:0]  remain;
  logic              blkErr;
  logic [PACE_W-1:0] pace;
  hgc_ecc_if         eccBus ();
  wire  [PACE_W-1:0] paceStep = rateHalf ? PACE_STEP_HALF : PACE_STEP_FULL;
  wire  [PACE_W:0]   paceSum  = {1'b0, pace} + {1'b0, paceStep};
  wire               take     = (hsState == HS_DATA) & hsWordValid & hsReady;
  wire               overrun  = take & (remain == '0);
  wire               shortBlk = take & hsLast & (remain != LEN_W'(1));
  wire               badWord  = take & eccBus.double;

  assign eccBus.data  = hsData;
  assign eccBus.check = hsCheck;

  // Check-bit decode of the incoming word
  hgc_ecc u_ecc
  (
    .e (eccBus)
  );

  // Block sequencing
  always_comb
  begin
    next_hsState = hsState;
    case (hsState)
      HS_IDLE:
      begin
        if (hsStart)
          next_hsState = HS_DATA;
      end
      HS_DATA:
      begin
        if (take & hsLast)
          next_hsState = HS_END;
      end
      HS_END:
        next_hsState = HS_IDLE;
      default:
        next_hsState = HS_IDLE;
    endcase
    if (hsClear)
      next_hsState = HS_IDLE;
  end

  // Address, length and block error tracking
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hsState <= HS_IDLE;
      addr    <= '0;
      remain  <= '0;
      blkErr  <= 1'b0;
    end
    else
    begin
      hsState <= next_hsState;
      if (hsClear)
        blkErr <= 1'b0;
      else if ((hsState == HS_IDLE) & hsStart)
      begin
        addr   <= hsAddr;
        remain <= hsLen;
        blkErr <= 1'b0;
      end
      else if (take)
      begin
        addr   <= addr + ADDR_W'(1);
        remain <= remain - LEN_W'(1);
        blkErr <= blkErr | badWord | overrun | shortBlk;
      end
    end
  end

  // Word pacing and memory write port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pace    <= '0;
      hsReady <= 1'b0;
      memWe   <= 1'b0;
      memAddr <= '0;
      memData <= '0;
    end
    else
    begin
      pace    <= paceSum[PACE_W-1:0];
      hsReady <= paceSum[PACE_W] & (next_hsState == HS_DATA) & ~(take & hsLast);
      memWe   <= take & ~overrun & ~hsClear;
      if (take)
      begin
        memAddr <= addr;
        memData <= eccBus.fixed;
      end
    end
  end

  // Block status back to the master
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hsStatusValid <= 1'b0;
      hsStatusErr   <= 1'b0;
    end
    else
    begin
      hsStatusValid <= (hsState == HS_END) & ~hsClear;
      hsStatusErr   <= (hsState == HS_END) & blkErr;
    end
  end

  // Sticky error flags; a new fault wins over a clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctlParityErr  <= 1'b0;
      dataUncorrErr <= 1'b0;
      dataCorrected <= 1'b0;
    end
    else
    begin
      ctlParityErr  <= parBad | (ctlParityErr & ~errClear);
      dataUncorrErr <= badWord | (dataUncorrErr & ~errClear);
      dataCorrected <= (take & eccBus.single) | (dataCorrected & ~errClear);
    end
  end

endmodule : hgc_top

// ---- hgc_top_asserts.sv ----
// Port-level assertions for the gateway channel logic
`timescale 1ns/100ps
module hgc_top_asserts
  import hgc_pkg::*;
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Control links
  input wire logic [CTL_W-1:0]     ciData,
  input wire logic [CTL_PAR_W-1:0] ciParity,
  input wire logic                 ciPresent,
  input wire logic                 ciTaken,
  input wire logic [CTL_W-1:0]     rxParcel,
  input wire logic [NODES-1:0]     rxValid,
  input wire logic [NODES-1:0]     nodeGrant,
  input wire logic [CTL_W-1:0]     coData,
  input wire logic [CTL_PAR_W-1:0] coParity,
  input wire logic                 coPresent,
  input wire logic                 coDone,
  input wire logic                 coTaken,
  // Data channel and flags
  input wire logic                 hsClear,
  input wire logic                 hsWordValid,
  input wire logic                 hsLast,
  input wire logic                 hsReady,
  input wire logic                 hsStatusValid,
  input wire logic                 memWe,
  input wire logic                 rateHalf,
  input wire logic                 errClear,
  input wire logic                 ctlParityErr
);
  wire logic [CTL_PAR_W-1:0] ciPar;
  wire logic [CTL_PAR_W-1:0] coPar;

  // Nibble parity expected on both links
  assign ciPar = {^ciData[15:12], ^ciData[11:8], ^ciData[7:4], ^ciData[3:0]};
  assign coPar = {^coData[15:12], ^coData[11:8], ^coData[7:4], ^coData[3:0]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Handshake steps
  sequence inTake;
    ciPresent && !ciTaken;
  endsequence
  sequence lastTake;
    hsWordValid && hsReady && hsLast && !hsClear ##1 memWe && !hsClear;
  endsequence

  AST_IN_ACK: assert property (inTake |=> ciTaken && $onehot(rxValid) && rxParcel == $past(ciData))
    else $error("inbound parcel not acked or delivered");
  AST_IN_DROP: assert property (!ciPresent && ciTaken |=> !ciTaken)
    else $error("inbound ack held after present dropped");
  AST_RX_QUIET: assert property (!(ciPresent && !ciTaken) |=> rxValid == 2'b00)
    else $error("delivery without a taken parcel");
  AST_GRANT_ONE: assert property ($onehot0(nodeGrant))
    else $error("outbound link owned by both nodes");
  AST_GRANT_HOLD: assert property (nodeGrant != 2'b00 && !coDone |=> nodeGrant == $past(nodeGrant))
    else $error("owner changed before disconnect");
  AST_CO_HOLD: assert property (coPresent && !coTaken |=> coPresent && $stable(coData))
    else $error("outbound parcel not held until taken");
  AST_CO_PAR: assert property (coPresent |-> coParity == coPar)
    else $error("outbound parity wrong");
  AST_CO_DONE: assert property (coDone |=> !coDone && nodeGrant == 2'b00)
    else $error("done pulse too long or owner kept");
  AST_IN_PAR: assert property (inTake and (ciParity != ciPar) |-> ##[1:2] ctlParityErr)
    else $error("inbound parity fault not flagged");
  AST_ERR_HOLD: assert property (ctlParityErr && !errClear |=> ctlParityErr)
    else $error("parity flag lost without clear");
  AST_HALF_RATE: assert property (hsReady && rateHalf ##1 rateHalf |-> !hsReady)
    else $error("half rate slots back to back");
  AST_LAST_STATUS: assert property (lastTake |=> hsStatusValid)
    else $error("no status after final word");
  AST_STATUS_PULSE: assert property (hsStatusValid |=> !hsStatusValid)
    else $error("status pulse too long");
endmodule : hgc_top_asserts

bind hgc_top hgc_top_asserts i_hgc_top_asserts (.clk, .rst, .ciData, .ciParity, .ciPresent, .ciTaken,
  .rxParcel, .rxValid, .nodeGrant, .coData, .coParity, .coPresent, .coDone, .coTaken, .hsClear,
  .hsWordValid, .hsLast, .hsReady, .hsStatusValid, .memWe, .rateHalf, .errClear, .ctlParityErr);

// ---- hgc_host_model.sv ----
// Far-end receiver model for the outbound control link
`timescale 1ns/100ps
module hgc_host_model
  import hgc_pkg::*;
(
  // Clock, reset and response delay
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [3:0]           lag,
  // Outbound control link
  input  wire logic [CTL_W-1:0]     coData,
  input  wire logic [CTL_PAR_W-1:0] coParity,
  input  wire logic                 coPresent,
  input  wire logic                 coDone,
  output logic                      coTaken,
  // Observations for the bench
  output logic      [CTL_W-1:0]     gotParcel,
  output int                        parErrCount,
  output int                        doneCount
);
  int waitCnt;

  // Four-phase ack, each phase delayed by lag cycles
  always @(posedge clk)
  begin
    if (rst)
    begin
      coTaken     <= 1'b0;
      gotParcel   <= '0;
      parErrCount <= 0;
      doneCount   <= 0;
      waitCnt     <= 0;
    end
    else
    begin
      if (coDone)
        doneCount <= doneCount + 1;
      if (coPresent === coTaken)
        waitCnt <= 0;
      else if (waitCnt < int'(lag))
        waitCnt <= waitCnt + 1;
      else
      begin
        waitCnt <= 0;
        coTaken <= coPresent;
        if (coPresent)
          gotParcel <= coData;
        if (coPresent && coParity !== {^coData[15:12], ^coData[11:8], ^coData[7:4], ^coData[3:0]})
          parErrCount <= parErrCount + 1;
      end
    end
  end
endmodule : hgc_host_model

// ---- testbench.sv ----
// Self-checking bench for the gateway channel logic
`timescale 1ns/100ps
module testbench;
  import hgc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ciPresent, ciDone, ciTaken, coPresent, coDone, coTaken, hsClear, hsStart, hsWordValid, hsLast;
  logic hsReady, hsStatusValid, hsStatusErr, memWe, rateHalf, errClear;
  logic ctlParityErr, dataUncorrErr, dataCorrected;
  logic [CTL_W-1:0]     ciData, rxParcel, coData, gotParcel;
  logic [CTL_W-1:0]     nodeParcel [NODES];
  logic [CTL_PAR_W-1:0] ciParity, coParity;
  logic [NODES-1:0]     rxValid, rxEnd, nodeReq, nodeValid, nodeDisc, nodeGrant, nodeReady;
  logic [ADDR_W-1:0]    hsAddr, memAddr;
  logic [LEN_W-1:0]     hsLen;
  logic [WORD_W-1:0]    hsData, memData;
  logic [CHK_W-1:0]     hsCheck;
  logic [3:0]           lag;
  int                   parErrCount, doneCount;
  int                   badCount = 0;
  int                   cmpCount = 0;

  hgc_top i_hgc_top (.clk, .rst, .ciData, .ciParity, .ciPresent, .ciDone, .ciTaken, .rxParcel, .rxValid,
    .rxEnd, .nodeReq, .nodeParcel, .nodeValid, .nodeDisc, .nodeGrant, .nodeReady, .coData, .coParity,
    .coPresent, .coDone, .coTaken, .hsClear, .hsStart, .hsAddr, .hsLen, .hsWordValid, .hsData, .hsCheck,
    .hsLast, .hsReady, .hsStatusValid, .hsStatusErr, .memWe, .memAddr, .memData, .rateHalf, .errClear,
    .ctlParityErr, .dataUncorrErr, .dataCorrected);

  hgc_host_model i_hgc_host_model (.clk, .rst, .lag, .coData, .coParity, .coPresent, .coDone, .coTaken,
    .gotParcel, .parErrCount, .doneCount);

  // Clock
  always #12.5 clk = ~clk;

  function automatic logic [3:0] par4(input logic [15:0] d);
    return {^d[15:12], ^d[11:8], ^d[7:4], ^d[3:0]};
  endfunction : par4

  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (badCount == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic sendIn(input logic [15:0] d, input logic bad, input logic [1:0] exp);
    ciData    = d;
    ciParity  = par4(d) ^ {3'h0, bad};
    ciPresent = 1'b1;
    tick();
    check(ciTaken, 1'b1);
    check(rxValid, exp);
    check(rxParcel, d);
    ciPresent = 1'b0;
    tick();
    check(ciTaken, 1'b0);
    check(rxValid, 2'b00);
    check(ctlParityErr, bad);
  endtask : sendIn

  task automatic endIn(input logic [1:0] exp);
    ciDone = 1'b1;
    tick();
    ciDone = 1'b0;
    check(rxEnd, exp);
  endtask : endIn

  task automatic testInbound();
    endIn(2'b00);
    sendIn(16'h7ABC, 1'b0, 2'b01);
    sendIn(16'hC123, 1'b0, 2'b01);
    endIn(2'b01);
    sendIn(16'h8001, 1'b0, 2'b10);
    endIn(2'b10);
    sendIn(16'h0F0F, 1'b1, 2'b01);
    endIn(2'b01);
    errClear = 1'b1;
    tick();
    errClear = 1'b0;
    tick();
    check(ctlParityErr, 1'b0);
  endtask : testInbound

  task automatic sendOut(input int n, input logic [15:0] d);
    for (int i = 0; i < 40 && nodeReady[n] !== 1'b1; i++)
      tick();
    nodeParcel[n] = d;
    nodeValid[n]  = 1'b1;
    tick();
    nodeValid[n] = 1'b0;
    check(coPresent, 1'b1);
    check(coData, d);
    check(coParity, par4(d));
    for (int i = 0; i < 40 && nodeReady[n] !== 1'b1; i++)
      tick();
    check(gotParcel, d);
  endtask : sendOut

  task automatic disc(input int n);
    for (int i = 0; i < 40 && nodeReady[n] !== 1'b1; i++)
      tick();
    nodeDisc[n] = 1'b1;
    tick();
    nodeDisc[n] = 1'b0;
    check(coDone, 1'b1);
  endtask : disc

  task automatic testOutbound();
    nodeReq = 2'b11;
    tick();
    check(nodeGrant, 2'b01);
    sendOut(0, 16'h5A3C);
    lag = 4'h3;
    sendOut(0, 16'h0001);
    check(nodeGrant, 2'b01);
    nodeReq = 2'b10;
    disc(0);
    for (int i = 0; i < 8 && nodeGrant !== 2'b10; i++)
      tick();
    check(nodeGrant, 2'b10);
    sendOut(1, 16'hFFFF);
    nodeReq = 2'b00;
    disc(1);
    // Far end counts the second done pulse one edge later
    tick();
    check(doneCount, 2);
    check(parErrCount, 0);
  endtask : testOutbound

  task automatic word(input logic [63:0] d, input logic last, input logic [23:0] a, input logic chk);
    hsData      = d;
    hsCheck     = 8'h00;
    hsLast      = last;
    hsWordValid = 1'b1;
    for (int i = 0; i < 40 && hsReady !== 1'b1; i++)
      tick();
    tick();
    // Valid stays up between words of one block
    if (last)
    begin
      hsWordValid = 1'b0;
      hsLast      = 1'b0;
    end
    check(memWe, 1'b1);
    check(memAddr, a);
    if (chk)
      check(memData, 64'h0);
  endtask : word

  task automatic hsBlock(input logic half, input logic [15:0] len, input logic [63:0] w0, input logic [63:0] w1,
                         input int slots, input logic err, input logic chk);
    int n;
    n        = 0;
    rateHalf = half;
    hsAddr   = 24'h0000F0;
    hsLen    = len;
    hsStart  = 1'b1;
    tick();
    hsStart = 1'b0;
    repeat (16)
    begin
      n = n + int'(hsReady === 1'b1);
      tick();
    end
    check(n, slots);
    word(w0, 1'b0, 24'h0000F0, chk);
    word(w1, 1'b1, 24'h0000F1, chk);
    tick();
    check(hsStatusValid, 1'b1);
    check(hsStatusErr, err);
  endtask : hsBlock

  task automatic testData();
    int n;
    hsBlock(1'b0, 16'h0002, 64'h1, 64'h8000_0000_0000_0000, 10, 1'b0, 1'b1);
    check(dataCorrected, 1'b1);
    check(dataUncorrErr, 1'b0);
    hsBlock(1'b1, 16'h0002, 64'h3, 64'h0, 5, 1'b1, 1'b0);
    check(dataUncorrErr, 1'b1);
    hsBlock(1'b0, 16'h0003, 64'h0, 64'h0, 10, 1'b1, 1'b1);
    // Clear aborts a started block: no slots and no status follow
    hsStart = 1'b1;
    tick();
    hsStart = 1'b0;
    hsClear = 1'b1;
    tick();
    hsClear = 1'b0;
    n       = 0;
    repeat (8)
    begin
      n = n + int'(hsReady === 1'b1) + int'(hsStatusValid === 1'b1);
      tick();
    end
    check(n, 0);
  endtask : testData

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    badCount++;
    conclude();
  end

  // Main sequence
  initial
  begin
    {ciData, ciParity, ciPresent, ciDone, nodeReq, nodeValid, nodeDisc, errClear} = '0;
    {hsClear, hsStart, hsAddr, hsLen, hsWordValid, hsData, hsCheck, hsLast, rateHalf} = '0;
    nodeParcel[0] = '0;
    nodeParcel[1] = '0;
    lag           = 4'h0;
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    tick();
    testInbound();
    testOutbound();
    testData();
    conclude();
  end
endmodule : testbench
